// ==== rtl/sotc_pkg.sv ====
// package: register map, field layout, reset values and timing of the synth tune control
package sotc_pkg;

	localparam logic [7:0] OFS_PIN_OVERRIDE = 8'h58; // synth_pin_override
	localparam logic [7:0] OFS_TUNE_CODE    = 8'h59; // oscillator_tune_code
	localparam logic [7:0] OFS_HOLD         = 8'h5c; // synth_hold_control
	localparam logic [7:0] OFS_TUNE_CTRL    = 8'h5d; // tune_engine_control
	localparam logic [7:0] OFS_TUNE_STATUS  = 8'h5e; // tune_engine_status

	localparam int POS_OVR_SELECT  = 7;
	localparam int POS_REFOUT_C_LO = 2;
	localparam int POS_SE_SELECT   = 1;
	localparam int POS_SYNTH_ON    = 0;
	localparam int POS_HOLD        = 0;
	localparam int POS_ENGINE_GO   = 0;
	localparam int POS_SETTLE_LO   = 4;
	localparam int POS_FINISHED    = 0;

	localparam logic [7:0] RST_PIN_OVERRIDE = 8'h00;
	localparam logic [6:0] RST_TUNE_CODE    = 7'h00;
	localparam logic [7:0] RST_HOLD         = 8'h00;
	localparam logic [7:0] RST_TUNE_CTRL    = 8'h40;

	// writable bit masks: reserved bits stay zero
	localparam logic [7:0] MASK_PIN_OVERRIDE = 8'hbf;
	localparam logic [7:0] MASK_HOLD         = 8'h01;
	localparam logic [7:0] MASK_TUNE_CTRL    = 8'h71;

	// settle wait per tune step: base time times (select + 1)
	localparam int SETTLE_BASE_NS  = 256;
	localparam int CLK_PERIOD_NS   = 8;
	localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [6:0] TUNE_MID = 7'h40;

	typedef enum logic [3:0] {
		ST_HOLD   = 4'b0001,
		ST_STEP   = 4'b0010,
		ST_SETTLE = 4'b0100,
		ST_DONE   = 4'b1000
	} sotc_state_t;

endpackage : sotc_pkg

// ==== rtl/sotc_ctrl.sv ====
// synth override, refout divider select and automatic oscillator tune engine
// Behaviour
// - override set: field picks refout c divider
// - override clear: straps pick refout c
// - override set: bit selects single-ended reference
// - override set: bit enables synthesizer
// - seven-bit tune code, software and engine written
// - settle select, reset 4, sets wait
// - run starts when hold written zero
// - engine steers code to centre oscillator
// - status register read-only, writes ignored
// - finished bit set after run or skip
module sotc_ctrl (
	input  wire logic       clk,                // 125 MHz register clock
	input  wire logic       nrst,               // async reset, active low
	input  wire logic       reg_wr,             // register write strobe
	input  wire logic       reg_rd,             // register read strobe
	input  wire logic [7:0] reg_addr,           // register offset
	input  wire logic [7:0] reg_wdata,          // write data
	output logic      [7:0] reg_rdata,          // read data, valid cycle after reg_rd
	input  wire logic       clock_strap_zero,   // strap pin, async
	input  wire logic       clock_strap_one,    // strap pin, async
	input  wire logic       single_ended_ref_strap, // strap pin, async
	input  wire logic       synth_enable_strap, // strap pin, async
	input  wire logic       osc_fast,           // oscillator above centre, async
	output logic            synth_on,           // synthesizer enable
	output logic            single_ended_ref_input_sel, // use single-ended reference
	output logic      [1:0] reference_out_c,    // 0 off, 1 div1, 2 div2, 3 div4
	output logic      [6:0] oscillator_tune_code, // tune code to oscillator
	output logic            synth_hold          // synthesizer held in reset
);

	logic [7:0] ovr_q;
	logic [6:0] code_q;
	logic       hold_q;
	logic [7:0] ctrl_q;
	logic       finished_q;
	logic [3:0] strap_m_q, strap_q;
	logic [1:0] fast_s_q;
	sotc_pkg::sotc_state_t state_q;
	logic [6:0] step_q;
	logic [15:0] wait_q;

	// one write decode shared by the four writable register offsets
	function automatic logic hits(input logic strobe, input logic [7:0] addr,
		input logic [7:0] ofs);
		hits = strobe && (addr == ofs);
	endfunction : hits

	logic wr_ovr;
	logic wr_code;
	logic wr_hold;
	logic wr_ctrl;
	logic hold_release;
	logic hold_set;
	assign wr_ovr  = hits(reg_wr, reg_addr, sotc_pkg::OFS_PIN_OVERRIDE);
	assign wr_code = hits(reg_wr, reg_addr, sotc_pkg::OFS_TUNE_CODE);
	assign wr_hold = hits(reg_wr, reg_addr, sotc_pkg::OFS_HOLD);
	assign wr_ctrl = hits(reg_wr, reg_addr, sotc_pkg::OFS_TUNE_CTRL);
	assign hold_release = wr_hold && !reg_wdata[sotc_pkg::POS_HOLD];
	// a hold write with the hold bit set in mid-run aborts the engine
	assign hold_set     = wr_hold && reg_wdata[sotc_pkg::POS_HOLD];

	// keep or drop the bit under test
	logic [6:0] next_code;
	assign next_code = fast_s_q[1] ? (code_q & ~step_q) : code_q;

	logic engine_go;
	logic [2:0] settle_sel;
	assign engine_go  = ctrl_q[sotc_pkg::POS_ENGINE_GO];
	assign settle_sel = ctrl_q[sotc_pkg::POS_SETTLE_LO +: 3];

	// straps come from pins: two-stage synchronisers
	// the first stage may go metastable, so only strap_q is read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_m_q <= 4'h0;
			strap_q   <= 4'h0;
		end else begin
			strap_m_q <= {synth_enable_strap, single_ended_ref_strap,
				clock_strap_one, clock_strap_zero};
			strap_q   <= strap_m_q;
		end
	end

	// comparator runs off the oscillator, not off clk
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fast_s_q <= 2'h0;
		end else begin
			fast_s_q <= {fast_s_q[0], osc_fast};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ovr_q <= sotc_pkg::RST_PIN_OVERRIDE;
		end else if (wr_ovr) begin
			ovr_q <= reg_wdata & sotc_pkg::MASK_PIN_OVERRIDE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold_q <= sotc_pkg::RST_HOLD[0];
		end else if (wr_hold) begin
			hold_q <= reg_wdata[sotc_pkg::POS_HOLD];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= sotc_pkg::RST_TUNE_CTRL;
		end else if (wr_ctrl) begin
			ctrl_q <= reg_wdata & sotc_pkg::MASK_TUNE_CTRL;
		end
	end

	// wait grows linearly with the select; the top select gives eight base units
	function automatic logic [15:0] settle_cycles(input logic [2:0] sel);
		settle_cycles = 16'(sotc_pkg::SETTLE_BASE_CYC * (int'(sel) + 1));
	endfunction : settle_cycles

	// tune engine: binary search from the top bit down
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= sotc_pkg::ST_HOLD;
			code_q     <= sotc_pkg::RST_TUNE_CODE;
			step_q     <= 7'h00;
			wait_q     <= 16'h0000;
			finished_q <= 1'b0;
		end else begin
			unique case (state_q)
				sotc_pkg::ST_HOLD: begin
					if (wr_code)
						code_q <= reg_wdata[6:0];
					if (hold_release && !engine_go) begin
						finished_q <= 1'b1;
						state_q    <= sotc_pkg::ST_DONE;
					end else if (hold_release) begin
						code_q  <= sotc_pkg::TUNE_MID;
						step_q  <= sotc_pkg::TUNE_MID;
						wait_q  <= settle_cycles(settle_sel);
						state_q <= sotc_pkg::ST_SETTLE;
					end
				end
				sotc_pkg::ST_SETTLE: begin
					if (hold_set) begin
						state_q <= sotc_pkg::ST_HOLD;
					end else if (wait_q <= 16'h0001) begin
						state_q <= sotc_pkg::ST_STEP;
					end else begin
						wait_q <= wait_q - 16'h0001;
					end
				end
				sotc_pkg::ST_STEP: begin
					// commit bit, try the next one down
					if (hold_set) begin
						state_q <= sotc_pkg::ST_HOLD;
					end else if (step_q == 7'h01) begin
						code_q     <= next_code;
						finished_q <= 1'b1;
						state_q    <= sotc_pkg::ST_DONE;
					end else begin
						code_q  <= next_code | (step_q >> 1);
						step_q  <= step_q >> 1;
						wait_q  <= settle_cycles(settle_sel);
						state_q <= sotc_pkg::ST_SETTLE;
					end
				end
				sotc_pkg::ST_DONE: begin
					if (wr_code)
						code_q <= reg_wdata[6:0];
					if (hold_set) begin
						finished_q <= 1'b0;
						state_q    <= sotc_pkg::ST_HOLD;
					end else if (hold_release) begin
						finished_q <= !engine_go;
						if (engine_go) begin
							code_q  <= sotc_pkg::TUNE_MID;
							step_q  <= sotc_pkg::TUNE_MID;
							wait_q  <= settle_cycles(settle_sel);
							state_q <= sotc_pkg::ST_SETTLE;
						end
					end
				end
			endcase
		end
	end

	// override bit chooses the register field over the synchronised strap
	function automatic logic pick1(input logic sel, input logic reg_val,
		input logic strap_val);
		pick1 = sel ? reg_val : strap_val;
	endfunction : pick1

	function automatic logic [1:0] pick2(input logic sel, input logic [1:0] reg_val,
		input logic [1:0] strap_val);
		pick2 = sel ? reg_val : strap_val;
	endfunction : pick2

	logic ovr_on;
	assign ovr_on = ovr_q[sotc_pkg::POS_OVR_SELECT];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			synth_on <= 1'b0;
		end else begin
			synth_on <= pick1(ovr_on, ovr_q[sotc_pkg::POS_SYNTH_ON], strap_q[3]);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			single_ended_ref_input_sel <= 1'b0;
		end else begin
			single_ended_ref_input_sel <= pick1(ovr_on, ovr_q[sotc_pkg::POS_SE_SELECT],
				strap_q[2]);
		end
	end

	// divider field when override is set; straps pick refout c when it is clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reference_out_c <= 2'h0;
		end else begin
			reference_out_c <= pick2(ovr_on, ovr_q[sotc_pkg::POS_REFOUT_C_LO +: 2],
				strap_q[1:0]);
		end
	end

	// tune code output lags the register by one cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oscillator_tune_code <= 7'h00;
		end else begin
			oscillator_tune_code <= code_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			synth_hold <= 1'b0;
		end else begin
			synth_hold <= hold_q;
		end
	end

	// read mux; status has no write path
	function automatic logic [7:0] reg_view(input logic [7:0] addr);
		unique case (addr)
			sotc_pkg::OFS_PIN_OVERRIDE: reg_view = ovr_q;
			sotc_pkg::OFS_TUNE_CODE:    reg_view = {1'b0, code_q};
			sotc_pkg::OFS_HOLD:         reg_view = {7'h00, hold_q};
			sotc_pkg::OFS_TUNE_CTRL:    reg_view = ctrl_q;
			sotc_pkg::OFS_TUNE_STATUS:  reg_view = {7'h00, finished_q};
			default:                    reg_view = 8'h00;
		endcase
	endfunction : reg_view

	// read data is registered and holds until the next read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= reg_view(reg_addr);
		end
	end

endmodule : sotc_ctrl

// ==== test/sotc_ctrl_props.sv ====
// checker: port properties of the synth tune control
module sotc_ctrl_props (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       synth_on,
	input wire logic       single_ended_ref_input_sel,
	input wire logic [1:0] reference_out_c,
	input wire logic [6:0] oscillator_tune_code,
	input wire logic       synth_hold
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_ovr; reg_wr && reg_addr == 8'h58 && reg_wdata[7]; endsequence
	// hold seen one cycle late, so the check waits for it
	sequence s_code; reg_wr && reg_addr == 8'h59 ##1 synth_hold; endsequence
	sequence s_strd; reg_rd && reg_addr == 8'h5e; endsequence
	property p_refout; s_ovr |-> ##2 reference_out_c == $past(reg_wdata[3:2], 2); endproperty
	a_refout: assert property (p_refout) else $error("refout mismatch");
	property p_se; s_ovr |-> ##2 single_ended_ref_input_sel == $past(reg_wdata[1], 2); endproperty
	a_se: assert property (p_se) else $error("ref select mismatch");
	property p_on; s_ovr |-> ##2 synth_on == $past(reg_wdata[0], 2); endproperty
	a_on: assert property (p_on) else $error("synth enable mismatch");
	property p_code; s_code |-> ##1 oscillator_tune_code == $past(reg_wdata[6:0], 2); endproperty
	a_code: assert property (p_code) else $error("tune code mismatch");
	property p_hold; reg_wr && reg_addr == 8'h5c |-> ##2 synth_hold == $past(reg_wdata[0], 2);
	endproperty
	a_hold: assert property (p_hold) else $error("hold mismatch");
	property p_rsv; s_strd |=> reg_rdata[7:1] == 7'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("status reserved set");
	property p_held; s_strd ##1 synth_hold |-> reg_rdata[0] == 1'b0; endproperty
	a_held: assert property (p_held) else $error("finished under hold");
	property p_unmap; reg_rd && reg_addr == 8'h5a |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : sotc_ctrl_props

bind sotc_ctrl sotc_ctrl_props u_props (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .synth_on(synth_on),
	.single_ended_ref_input_sel(single_ended_ref_input_sel), .reference_out_c(reference_out_c),
	.oscillator_tune_code(oscillator_tune_code), .synth_hold(synth_hold));

// ==== test/tb_synth_override_and_tune_control.sv ====
// testbench: registers, pin override and tune engine of the synth tune control
module tb_synth_override_and_tune_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, nrst, reg_wr, reg_rd, osc_fast, strap0, strap1, se_strap, en_strap;
	logic       synth_on, se_sel, synth_hold;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] refout;
	logic [6:0] code;
	int         n_fail, compares;
	sotc_ctrl dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clock_strap_zero(strap0),
		.clock_strap_one(strap1), .single_ended_ref_strap(se_strap),
		.synth_enable_strap(en_strap), .osc_fast(osc_fast), .synth_on(synth_on),
		.single_ended_ref_input_sel(se_sel), .reference_out_c(refout),
		.oscillator_tune_code(code), .synth_hold(synth_hold));
	always #4 clk = ~clk;
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rchk(string what, logic [7:0] a, logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(what, reg_rdata, exp);
	endtask : rchk
	task automatic t_reset_values;
		rchk("override", 8'h58, 8'h00);
		rchk("code", 8'h59, 8'h00);
		rchk("hold", 8'h5c, 8'h00);
		rchk("ctrl", 8'h5d, 8'h40);
		rchk("unmapped", 8'h5a, 8'h00);
		rchk("status", 8'h5e, 8'h00);
	endtask : t_reset_values
	task automatic t_override;
		for (int m = 0; m < 4; m++) begin
			wr(8'h58, {4'h8, 2'(m), 1'(m >> 1), 1'(m)});
			repeat (2) @(negedge clk);
			chk("refout", {6'h00, refout}, 8'(m));
			chk("se sel", {7'h00, se_sel}, 8'(m >> 1));
			chk("synth on", {7'h00, synth_on}, 8'(m & 1));
		end
	endtask : t_override
	task automatic t_straps;
		wr(8'h58, 8'h3f);
		for (int m = 0; m < 4; m++) begin
			{strap1, strap0} = 2'(m);
			se_strap = 1'(m);
			en_strap = 1'(m >> 1);
			repeat (4) @(negedge clk);
			chk("strap refout", {6'h00, refout}, 8'(m));
			chk("strap se", {7'h00, se_sel}, 8'(m & 1));
			chk("strap on", {7'h00, synth_on}, 8'(m >> 1));
		end
	endtask : t_straps
	task automatic t_tune(logic go, logic [2:0] sel, logic fast, logic [6:0] exp_code);
		int n;
		int lo;
		lo = go ? 224 * (int'(sel) + 1) : 2;
		osc_fast = fast;
		wr(8'h5c, 8'h01);
		wr(8'h5d, {1'b0, sel, 3'h0, go});
		rchk("held status", 8'h5e, 8'h00);
		wr(8'h5c, 8'h00);
		n = 0;
		// only the status register is polled while the engine runs
		do begin
			@(negedge clk);
			reg_rd = 1'b1;
			reg_addr = 8'h5e;
			@(negedge clk);
			reg_rd = 1'b0;
			n += 2;
		end while (reg_rdata[0] !== 1'b1 && n < 3000);
		chk("run cycles", 8'(n >= lo && n <= (go ? lo + 40 : 2)), 8'h01);
		chk("finished", reg_rdata, 8'h01);
		rchk("tuned code", 8'h59, {1'b0, exp_code});
		chk("code out", {1'b0, code}, {1'b0, exp_code});
	endtask : t_tune
	task automatic t_restore;
		wr(8'h5c, 8'h01);
		wr(8'h59, 8'h55);
		rchk("restored", 8'h59, 8'h55);
		wr(8'h5e, 8'h01);
		rchk("status ro held", 8'h5e, 8'h00);
		t_tune(1'b0, 3'h4, 1'b0, 7'h55);
		wr(8'h5e, 8'h00);
		rchk("status ro", 8'h5e, 8'h01);
	endtask : t_restore
	task automatic complete_run;
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	initial begin
		#160000;
		n_fail++;
		complete_run();
	end
	initial begin
		{clk, nrst, reg_wr, reg_rd, osc_fast, strap0, strap1, se_strap, en_strap} = 9'h000;
		{reg_addr, reg_wdata} = 16'h0000;
		n_fail = 0;
		compares = 0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		t_reset_values();
		t_override();
		t_straps();
		t_tune(1'b1, 3'h0, 1'b0, 7'h7f);
		t_tune(1'b1, 3'h4, 1'b1, 7'h00);
		t_restore();
		complete_run();
	end
endmodule : tb_synth_override_and_tune_control
